// [design/isc_pkg.sv]
// constants for the interrupt option and sleep sequencing block
// assumes a single 250 mhz clock and an ahb-lite register port
package isc_pkg;
  localparam logic [7:0] IOPT_OFFSET = 8'hc8;
  localparam logic [7:0] STATUS_OFFSET = 8'hcc;
  localparam logic [7:0] IOPT_RESET = 8'h00;
  localparam logic [7:0] IOPT_WMASK = 8'h70;
  localparam int LES_BIT = 6;
  localparam int ESB_BIT = 5;
  localparam int GEN_BIT = 4;
  localparam int STAT_REQ_LSB = 0;
  localparam int STAT_NMI_REQ_BIT = 4;
  localparam int STAT_IRQ_MODE_BIT = 6;
  localparam int STAT_NMI_MODE_BIT = 7;
  localparam int STAT_STATE_LSB = 8;
  localparam int CLK_PER_CPU = 13;
  localparam int LAT_MIN_CPU = 6;
  localparam int LAT_MAX_CPU = 11;
  localparam int STARTUP_SHORT = 2048;
  localparam int STARTUP_LONG = 32768;
  localparam logic [11:0] VEC_RESET = 12'hffe;
  localparam logic [11:0] VEC_NMI = 12'hffc;
  localparam logic [11:0] VEC_PORT_A = 12'hff6;
  localparam logic [11:0] VEC_PORT_B = 12'hff4;
  localparam logic [11:0] VEC_TIMER = 12'hff2;
  localparam logic [11:0] VEC_CONV = 12'hff0;
  localparam logic [11:0] VEC_RESET_VALUE = 12'h000;
  localparam logic [3:0] LAT_RESET = 4'h0;
  localparam logic [15:0] OSC_CNT_RESET = 16'h0000;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  typedef enum logic [4:0] {
    ST_RUN = 5'h01,
    ST_WAIT = 5'h02,
    ST_STOP = 5'h04,
    ST_OSC = 5'h08,
    ST_VEC = 5'h10
  } isc_state_t;
endpackage : isc_pkg

// [design/isc_cpu_clock.sv]
// cpu cycle prescaler: one tick every thirteen oscillator clocks
// assumes restart_in is a one-cycle pulse from the sequencer
module isc_cpu_clock (
  input wire logic clk_in, // oscillator clock
  input wire logic rst_n_in, // synchronous reset, active low
  input wire logic restart_in, // realign the cpu cycle
  output logic tick_out // last clock of a cpu cycle
);
  typedef struct packed {
    logic [3:0] cnt;
  } isc_clk_state_t;
  isc_clk_state_t q;
  isc_clk_state_t s;

  always_comb begin
    s = q;
    if (restart_in) begin
      s.cnt = 4'h0;
    end else if (q.cnt == 4'(isc_pkg::CLK_PER_CPU - 1)) begin
      s.cnt = 4'h0;
    end else begin
      s.cnt = q.cnt + 4'h1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      q.cnt <= 4'h0;
    end else begin
      q <= s;
    end
  end

  assign tick_out = !restart_in && (q.cnt == 4'(isc_pkg::CLK_PER_CPU - 1));
endmodule : isc_cpu_clock

// [design/isc_req_latch.sv]
// one external request line: edge latch or plain low level
// assumes the pin is already synchronous to clk_in
module isc_req_latch (
  input wire logic clk_in, // clock
  input wire logic rst_n_in, // synchronous reset, active low
  input wire logic pin_in, // request line
  input wire logic level_mode_in, // 1: low level, no storage
  input wire logic rising_in, // edge mode polarity, 1: rising
  input wire logic clear_in, // service routine started
  output logic req_out // request pending
);
  typedef struct packed {
    logic prev;
    logic latch;
  } isc_latch_state_t;
  isc_latch_state_t q;
  isc_latch_state_t s;
  logic edge_seen;

  always_comb begin
    edge_seen = rising_in ? (pin_in && !q.prev) : (!pin_in && q.prev);
    s.prev = pin_in;
    s.latch = q.latch;
    if (clear_in) begin
      s.latch = 1'b0;
    end
    // set beats clear; a second edge while latched adds nothing
    if (edge_seen && !level_mode_in) begin
      s.latch = 1'b1;
    end
    if (level_mode_in) begin
      s.latch = 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      // track the line during reset: a pin already at its active level is no edge
      q.prev <= pin_in;
      q.latch <= 1'b0;
    end else begin
      q <= s;
    end
  end

  assign req_out = level_mode_in ? !pin_in : q.latch;
endmodule : isc_req_latch

// [design/isc_top.sv]
// interrupt option register, vector arbitration and wait/stop sequencing
// assumes an ahb-lite master, a core that flags instruction boundaries,
// and peripheral flags that software clears itself
//
// The AHB-Lite slave port is this design's own decision.
module isc_top #(
  parameter int STARTUP_SHORT_CYC = isc_pkg::STARTUP_SHORT, // short start-up count
  parameter int STARTUP_LONG_CYC = isc_pkg::STARTUP_LONG // long start-up count
) (
  input wire logic clk_in, // 250 mhz clock
  input wire logic rst_n_in, // synchronous reset, active low
  input wire logic hsel_in, // ahb slave select
  input wire logic [31:0] haddr_in, // ahb address
  input wire logic [1:0] htrans_in, // ahb transfer type
  input wire logic hwrite_in, // ahb write
  input wire logic [2:0] hsize_in, // ahb size, word only
  input wire logic hready_in, // ahb bus ready
  input wire logic [31:0] hwdata_in, // ahb write data
  output logic [31:0] hrdata_out, // ahb read data
  output logic hreadyout_out, // ahb slave ready
  output logic hresp_out, // ahb response, always okay
  input wire logic nmi_pin_in, // non-maskable request pin
  input wire logic port_a_irq_in, // vector one line
  input wire logic port_b_irq_in, // vector two line
  input wire logic timer_zero_flag_in, // vector three flag
  input wire logic conv_done_flag_in, // vector four flag
  input wire logic timer_ext_clock_in, // timer runs from external clock
  input wire logic instr_boundary_in, // core between instructions
  input wire logic [2:0] instr_phase_in, // instruction phase at request
  input wire logic wait_exec_in, // core executes wait
  input wire logic stop_exec_in, // core executes stop
  input wire logic reti_in, // core executes return from interrupt
  input wire logic watchdog_active_in, // watchdog running
  input wire logic stop_with_watchdog_option_in, // option bit
  input wire logic long_startup_in, // long oscillator start-up
  output logic vector_load_out, // pc loaded with vector
  output logic [11:0] vector_addr_out, // vector address
  output logic service_ready_out, // service code may run
  output logic cpu_halt_out, // core frozen
  output logic osc_enable_out, // oscillator running
  output logic periph_clk_enable_out, // peripheral clock gate
  output logic watchdog_freeze_out, // watchdog held in stop
  output logic irq_mode_out, // core in maskable routine
  output logic nmi_mode_out // core in nmi routine
);
  typedef struct packed {
    isc_pkg::isc_state_t state;
    logic [7:0] iopt;
    logic wr_pend;
    logic [31:0] hrdata;
    logic irq_mode;
    logic nmi_mode;
    logic [3:0] lat;
    logic [15:0] osc_cnt;
    logic vec_load;
    logic [11:0] vec_addr;
    logic svc_ready;
    logic halt;
    logic osc_en;
    logic periph_en;
    logic wdg_freeze;
    logic [4:0] ack;
  } isc_top_state_t;

  isc_top_state_t q;
  isc_top_state_t s;
  logic cpu_tick;
  logic nmi_req;
  logic port_a_req;
  logic port_b_req;
  logic [3:0] m_req;
  logic gen;
  logic take_nmi;
  logic take_m;
  logic wake_wait;
  logic wake_stop;
  logic bus_valid;
  logic [1:0] pick;
  logic [2:0] phase;

  function automatic logic reg_hit(input logic [31:0] addr, input logic [7:0] off);
    reg_hit = (addr[31:8] == 24'h000000) && (addr[7:0] == off);
  endfunction : reg_hit

  function automatic logic [11:0] vec_of(input logic [1:0] idx);
    unique case (idx)
      2'd0: vec_of = isc_pkg::VEC_PORT_A;
      2'd1: vec_of = isc_pkg::VEC_PORT_B;
      2'd2: vec_of = isc_pkg::VEC_TIMER;
      2'd3: vec_of = isc_pkg::VEC_CONV;
    endcase
  endfunction : vec_of

  isc_cpu_clock u_cpu_clock (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .restart_in(q.vec_load),
    .tick_out(cpu_tick)
  );

  isc_req_latch u_nmi_latch (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .pin_in(nmi_pin_in),
    .level_mode_in(1'b0),
    .rising_in(1'b0),
    .clear_in(q.ack[0]),
    .req_out(nmi_req)
  );

  isc_req_latch u_port_a_latch (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .pin_in(port_a_irq_in),
    .level_mode_in(q.iopt[isc_pkg::LES_BIT]),
    .rising_in(1'b0),
    .clear_in(q.ack[1]),
    .req_out(port_a_req)
  );

  isc_req_latch u_port_b_latch (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .pin_in(port_b_irq_in),
    .level_mode_in(1'b0),
    .rising_in(q.iopt[isc_pkg::ESB_BIT]),
    .clear_in(q.ack[2]),
    .req_out(port_b_req)
  );

  // requests stay latched regardless of the enable bit
  assign m_req = {conv_done_flag_in, timer_zero_flag_in, port_b_req, port_a_req};
  assign gen = q.iopt[isc_pkg::GEN_BIT];
  assign take_nmi = nmi_req && !q.nmi_mode;
  assign take_m = gen && (|m_req) && !q.irq_mode && !q.nmi_mode;
  assign wake_wait = gen && (nmi_req || (|m_req));
  // conversion done has no path out of stop
  assign wake_stop = gen && (nmi_req || m_req[0] || m_req[1] || (m_req[2] && timer_ext_clock_in));
  assign bus_valid = hsel_in && hready_in && htrans_in[1];
  assign phase = (instr_phase_in > 3'd5) ? 3'd5 : instr_phase_in;

  always_comb begin
    pick = 2'd3;
    for (int i = 3; i >= 0; i--) begin
      if (m_req[i]) begin
        pick = 2'(i);
      end
    end
  end

  always_comb begin
    s = q;
    s.vec_load = 1'b0;
    s.svc_ready = 1'b0;
    s.ack = 5'h00;
    // bus slave: zero wait states, registered read data
    if (q.wr_pend && hready_in) begin
      s.iopt = hwdata_in[7:0] & isc_pkg::IOPT_WMASK;
    end
    if (hready_in) begin
      s.wr_pend = bus_valid && hwrite_in && reg_hit(haddr_in, isc_pkg::IOPT_OFFSET);
      s.hrdata = 32'h00000000;
      if (bus_valid && !hwrite_in && reg_hit(haddr_in, isc_pkg::STATUS_OFFSET)) begin
        s.hrdata[isc_pkg::STAT_REQ_LSB +: 4] = m_req;
        s.hrdata[isc_pkg::STAT_NMI_REQ_BIT] = nmi_req;
        s.hrdata[isc_pkg::STAT_IRQ_MODE_BIT] = q.irq_mode;
        s.hrdata[isc_pkg::STAT_NMI_MODE_BIT] = q.nmi_mode;
        s.hrdata[isc_pkg::STAT_STATE_LSB +: 5] = q.state;
      end
    end
    // sequencer; option register and latches are untouched by sleep
    unique case (q.state)
      isc_pkg::ST_RUN: begin
        if (instr_boundary_in && take_nmi) begin
          // nmi also preempts a maskable routine that just woke
          s.state = isc_pkg::ST_VEC;
          s.nmi_mode = 1'b1;
          s.ack[0] = 1'b1;
          s.vec_load = 1'b1;
          s.vec_addr = isc_pkg::VEC_NMI;
          s.lat = 4'(isc_pkg::LAT_MIN_CPU) + {1'b0, phase};
        end else if (instr_boundary_in && take_m) begin
          // waking request from main code is serviced here first
          s.state = isc_pkg::ST_VEC;
          s.irq_mode = 1'b1;
          s.ack[3'(pick) + 3'd1] = 1'b1;
          s.vec_load = 1'b1;
          s.vec_addr = vec_of(pick);
          s.lat = 4'(isc_pkg::LAT_MIN_CPU) + {1'b0, phase};
        end else if (instr_boundary_in && reti_in) begin
          // nmi return falls back to the maskable routine it preempted
          if (q.nmi_mode) begin
            s.nmi_mode = 1'b0;
          end else begin
            s.irq_mode = 1'b0;
          end
        end else if (instr_boundary_in && stop_exec_in) begin
          if (watchdog_active_in && !(stop_with_watchdog_option_in && nmi_pin_in)) begin
            s.state = isc_pkg::ST_WAIT;
          end else begin
            s.state = isc_pkg::ST_STOP;
            s.wdg_freeze = watchdog_active_in;
          end
        end else if (instr_boundary_in && wait_exec_in) begin
          s.state = isc_pkg::ST_WAIT;
        end
      end
      isc_pkg::ST_WAIT: begin
        // in nmi or maskable mode the wake only resumes; run state arbitrates
        if (wake_wait) begin
          s.state = isc_pkg::ST_RUN;
        end
      end
      isc_pkg::ST_STOP: begin
        if (wake_stop) begin
          s.state = isc_pkg::ST_OSC;
          s.osc_cnt = long_startup_in ? 16'(STARTUP_LONG_CYC - 1) : 16'(STARTUP_SHORT_CYC - 1);
        end
      end
      isc_pkg::ST_OSC: begin
        if (q.osc_cnt == 16'h0000) begin
          s.state = isc_pkg::ST_RUN;
          s.wdg_freeze = 1'b0;
        end else begin
          s.osc_cnt = q.osc_cnt - 16'h0001;
        end
      end
      isc_pkg::ST_VEC: begin
        if (cpu_tick) begin
          if (q.lat == 4'h1) begin
            s.state = isc_pkg::ST_RUN;
            s.svc_ready = 1'b1;
          end else begin
            s.lat = q.lat - 4'h1;
          end
        end
      end
    endcase
    s.halt = (s.state != isc_pkg::ST_RUN) && (s.state != isc_pkg::ST_VEC);
    s.osc_en = (s.state != isc_pkg::ST_STOP);
    s.periph_en = (s.state == isc_pkg::ST_RUN) || (s.state == isc_pkg::ST_WAIT)
      || (s.state == isc_pkg::ST_VEC);
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      q.state <= isc_pkg::ST_RUN;
      q.iopt <= isc_pkg::IOPT_RESET;
      q.wr_pend <= 1'b0;
      q.hrdata <= 32'h00000000;
      q.irq_mode <= 1'b0;
      q.nmi_mode <= 1'b0;
      q.lat <= isc_pkg::LAT_RESET;
      q.osc_cnt <= isc_pkg::OSC_CNT_RESET;
      q.vec_load <= 1'b0;
      q.vec_addr <= isc_pkg::VEC_RESET_VALUE;
      q.svc_ready <= 1'b0;
      q.halt <= 1'b0;
      q.osc_en <= 1'b1;
      q.periph_en <= 1'b1;
      q.wdg_freeze <= 1'b0;
      q.ack <= 5'h00;
    end else begin
      q <= s;
    end
  end

  assign hrdata_out = q.hrdata;
  assign hreadyout_out = rst_n_in || 1'b1;
  assign hresp_out = 1'b0;
  assign vector_load_out = q.vec_load;
  assign vector_addr_out = q.vec_addr;
  assign service_ready_out = q.svc_ready;
  assign cpu_halt_out = q.halt;
  assign osc_enable_out = q.osc_en;
  assign periph_clk_enable_out = q.periph_en;
  assign watchdog_freeze_out = q.wdg_freeze;
  assign irq_mode_out = q.irq_mode;
  assign nmi_mode_out = q.nmi_mode;

  // helper ages for the timing checks below
  logic [7:0] lat_age;
  logic [15:0] osc_age;
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      lat_age <= 8'h00;
      osc_age <= 16'h0000;
    end else begin
      lat_age <= q.vec_load ? 8'h01 : ((lat_age == 8'hff) ? lat_age : lat_age + 8'h01);
      osc_age <= (q.state == isc_pkg::ST_OSC) ? osc_age + 16'h0001 : 16'h0000;
    end
  end

  a_latency_window: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    service_ready_out |-> (lat_age >= 8'd79) && (lat_age <= 8'd144))
    else $error("service ready outside six to eleven cpu cycles");

  a_option_write: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (q.wr_pend && hready_in) |=> ({24'h000000, q.iopt} == ($past(hwdata_in) & 32'h00000070)))
    else $error("option register write not taken as masked byte");

  a_option_reads_zero: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (bus_valid && !hwrite_in && reg_hit(haddr_in, 8'hc8)) |=> (hrdata_out == 32'h00000000))
    else $error("write-only option register returned data");

  a_stop_becomes_wait: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ($changed(q.state) && q.state == isc_pkg::ST_STOP)
      |-> (!$past(watchdog_active_in) || ($past(stop_with_watchdog_option_in) && $past(nmi_pin_in))))
    else $error("stop entered while watchdog should force wait");

  a_stop_clocks_off: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (q.state == isc_pkg::ST_STOP) |-> (!osc_enable_out && !periph_clk_enable_out && cpu_halt_out))
    else $error("oscillator or peripheral clock running in stop");

  a_wait_clocks_on: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (q.state == isc_pkg::ST_WAIT) |-> (osc_enable_out && periph_clk_enable_out && cpu_halt_out))
    else $error("wait mode stopped the clocks or ran the core");

  a_startup_count: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ($past(q.state) == isc_pkg::ST_OSC && q.state != isc_pkg::ST_OSC)
      |-> (($past(osc_age) + 16'h0001 == 16'(STARTUP_SHORT_CYC))
        || ($past(osc_age) + 16'h0001 == 16'(STARTUP_LONG_CYC))))
    else $error("oscillator start-up delay of wrong length");

  a_stop_exit_path: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (q.state == isc_pkg::ST_STOP) ##1 (q.state != isc_pkg::ST_STOP) |-> (q.state == isc_pkg::ST_OSC))
    else $error("stop left without oscillator start-up");

  a_nmi_no_wake: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (q.state == isc_pkg::ST_WAIT && !gen) |=> (q.state == isc_pkg::ST_WAIT))
    else $error("woke from wait with maskable enable clear");

  a_conv_no_wake: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (q.state == isc_pkg::ST_STOP && !nmi_req && !m_req[0] && !m_req[1]
      && !(m_req[2] && timer_ext_clock_in)) |=> (q.state == isc_pkg::ST_STOP))
    else $error("stop left on a source that cannot wake it");
endmodule : isc_top

// [tb/isc_core_model.sv]
// behavioural cpu core: executes sleep requests and ends each routine with a return
// assumes one service_ready pulse marks the start of each service routine
module isc_core_model (
  input wire logic clk_in, // clock
  input wire logic rst_n_in, // synchronous reset, active low
  input wire logic service_ready_in, // routine may run
  input wire logic [1:0] sleep_in, // software: 1 wait, 2 stop
  output logic boundary_out, // between instructions
  output logic wait_out, // wait executed
  output logic stop_out, // stop executed
  output logic reti_out // routine finished
);
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      boundary_out <= 1'b0;
      wait_out <= 1'b0;
      stop_out <= 1'b0;
      reti_out <= 1'b0;
    end else begin
      boundary_out <= 1'b1;
      wait_out <= (sleep_in == 2'h1);
      stop_out <= (sleep_in == 2'h2);
      // short routines: return right after the first instruction
      reti_out <= service_ready_in;
    end
  end
endmodule : isc_core_model

// [tb/isc_top_tb.sv]
// self-checking bench for the option register and wait/stop sequencer
// assumes the core model above and short oscillator start-up counts
module isc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SHORT_CYC = 8;
  localparam int LONG_CYC = 16;
  logic clk_in = 1'b0, rst_n_in = 1'b0, hsel_in = 1'b0, hwrite_in = 1'b0, nmi_pin_in = 1'b1;
  logic port_a_irq_in = 1'b1, port_b_irq_in = 1'b0, timer_zero_flag_in = 1'b0, conv_done_flag_in = 1'b0;
  logic watchdog_active_in = 1'b0, opt_in = 1'b0, long_startup_in = 1'b0, ext_clk_in = 1'b1;
  logic [31:0] haddr_in = 32'h0, hwdata_in = 32'h0, hrdata_out, rd;
  logic [1:0] htrans_in = 2'h0, sleep_req = 2'h0;
  logic [2:0] instr_phase_in = 3'h0;
  logic hreadyout_out, hresp_out, vector_load_out, service_ready_out, cpu_halt_out, osc_enable_out;
  logic periph_clk_enable_out, watchdog_freeze_out, irq_mode_out, nmi_mode_out, bnd, wex, sex, rex;
  logic [11:0] vector_addr_out;
  int n_errors = 0, tests_run = 0, n_vec = 0, nv;
  always #2 clk_in = ~clk_in;
  isc_core_model core (.clk_in(clk_in), .rst_n_in(rst_n_in), .service_ready_in(service_ready_out),
    .sleep_in(sleep_req), .boundary_out(bnd), .wait_out(wex), .stop_out(sex), .reti_out(rex));
  isc_top #(.STARTUP_SHORT_CYC(SHORT_CYC), .STARTUP_LONG_CYC(LONG_CYC)) uut (.clk_in(clk_in),
    .rst_n_in(rst_n_in), .hsel_in(hsel_in), .haddr_in(haddr_in), .htrans_in(htrans_in),
    .hwrite_in(hwrite_in), .hsize_in(3'h2), .hready_in(hreadyout_out), .hwdata_in(hwdata_in),
    .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
    .nmi_pin_in(nmi_pin_in), .port_a_irq_in(port_a_irq_in), .port_b_irq_in(port_b_irq_in),
    .timer_zero_flag_in(timer_zero_flag_in), .conv_done_flag_in(conv_done_flag_in),
    .timer_ext_clock_in(ext_clk_in), .instr_boundary_in(bnd), .instr_phase_in(instr_phase_in),
    .wait_exec_in(wex), .stop_exec_in(sex), .reti_in(rex), .watchdog_active_in(watchdog_active_in),
    .stop_with_watchdog_option_in(opt_in), .long_startup_in(long_startup_in),
    .vector_load_out(vector_load_out), .vector_addr_out(vector_addr_out),
    .service_ready_out(service_ready_out), .cpu_halt_out(cpu_halt_out), .osc_enable_out(osc_enable_out),
    .periph_clk_enable_out(periph_clk_enable_out), .watchdog_freeze_out(watchdog_freeze_out),
    .irq_mode_out(irq_mode_out), .nmi_mode_out(nmi_mode_out));
  // service routines clear their peripheral flag, else a level flag retriggers
  always @(posedge clk_in) begin
    if (vector_load_out === 1'b1) begin
      n_vec <= n_vec + 1;
      if (vector_addr_out === isc_pkg::VEC_TIMER) timer_zero_flag_in <= 1'b0;
      if (vector_addr_out === isc_pkg::VEC_CONV) conv_done_flag_in <= 1'b0;
    end
  end
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int k;
    k = 0;
    hsel_in <= 1'b1;
    haddr_in <= a;
    htrans_in <= isc_pkg::HTRANS_NONSEQ;
    hwrite_in <= w;
    do begin @(posedge clk_in); k++; end while (hreadyout_out !== 1'b1 && k < 64);
    htrans_in <= 2'h0;
    hwdata_in <= d;
    do begin @(posedge clk_in); k++; end while (hreadyout_out !== 1'b1 && k < 64);
    rd = hrdata_out;
    chk("okay", 32'h0, {31'h0, hresp_out});
    if (k >= 64) begin n_errors++; report_and_stop(); end
  endtask : ahb
  task automatic sleep(input logic [1:0] m);
    sleep_req <= m;
    @(posedge clk_in);
    sleep_req <= 2'h0;
    repeat (5) @(posedge clk_in);
  endtask : sleep
  task automatic wait_vec(input logic [11:0] exp);
    int k, lat;
    k = 0;
    lat = 0;
    while (vector_load_out !== 1'b1 && k < 400) begin @(negedge clk_in); k++; end
    chk("vector", {20'h0, exp}, {20'h0, vector_addr_out});
    chk("mode", 32'h1, {31'h0, (exp == isc_pkg::VEC_NMI) ? nmi_mode_out : irq_mode_out});
    do begin @(negedge clk_in); lat++; end while (service_ready_out !== 1'b1 && lat < 400);
    if (k >= 400 || lat >= 400) begin n_errors++; report_and_stop(); end
    chk("latency", 32'(isc_pkg::CLK_PER_CPU * (isc_pkg::LAT_MIN_CPU + instr_phase_in) + 1), 32'(lat));
    @(posedge clk_in);
    instr_phase_in <= 3'($urandom_range(0, 5));
  endtask : wait_vec
  task automatic startup;
    int k, n;
    k = 0;
    n = 0;
    while (cpu_halt_out === 1'b1 && k < 200) begin
      @(negedge clk_in);
      k++;
      if (osc_enable_out === 1'b1 && cpu_halt_out === 1'b1) n++;
    end
    if (k >= 200) begin n_errors++; report_and_stop(); end
    chk("startup", 32'(long_startup_in ? LONG_CYC : SHORT_CYC), 32'(n));
  endtask : startup
  initial begin
    #400000;
    n_errors++;
    report_and_stop();
  end
  initial begin
    void'($urandom(32'hcd877282));
    repeat (12) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(negedge clk_in);
    chk("osc", 32'h1, {31'h0, osc_enable_out});
    chk("periph", 32'h1, {31'h0, periph_clk_enable_out});
    chk("halt", 32'h0, {31'h0, cpu_halt_out});
    @(posedge clk_in);
    ahb(1'b0, 32'h40, 32'h0);
    chk("unmapped", 32'h0, rd);
    for (int i = 0; i < 4; i++) begin
      ahb(1'b1, 32'(isc_pkg::IOPT_OFFSET), $urandom & 32'(isc_pkg::IOPT_WMASK));
      ahb(1'b0, 32'(isc_pkg::IOPT_OFFSET), 32'h0);
      chk("option_read", 32'h0, rd);
    end
    ahb(1'b1, 32'(isc_pkg::IOPT_OFFSET), 32'h10);
    ahb(1'b0, 32'(isc_pkg::STATUS_OFFSET), 32'h0);
    chk("status", 32'h100, rd);
    nmi_pin_in <= 1'b0;
    wait_vec(isc_pkg::VEC_NMI);
    nmi_pin_in <= 1'b1;
    ahb(1'b1, 32'(isc_pkg::IOPT_OFFSET), 32'h0);
    nv = n_vec;
    port_a_irq_in <= 1'b0;
    timer_zero_flag_in <= 1'b1;
    @(posedge clk_in);
    port_a_irq_in <= 1'b1;
    repeat (20) @(posedge clk_in);
    chk("masked", 32'(nv), 32'(n_vec));
    ahb(1'b1, 32'(isc_pkg::IOPT_OFFSET), 32'h10);
    wait_vec(isc_pkg::VEC_PORT_A);
    wait_vec(isc_pkg::VEC_TIMER);
    ahb(1'b1, 32'(isc_pkg::IOPT_OFFSET), 32'h30);
    long_startup_in <= 1'($urandom_range(0, 1));
    sleep(2'h2);
    chk("stop_osc", 32'h0, {31'h0, osc_enable_out});
    chk("stop_halt", 32'h1, {31'h0, cpu_halt_out});
    conv_done_flag_in <= 1'b1;
    repeat (10) @(posedge clk_in);
    chk("conv_no_wake", 32'h1, {31'h0, cpu_halt_out});
    conv_done_flag_in <= 1'b0;
    @(posedge clk_in);
    port_b_irq_in <= 1'b1;
    startup();
    wait_vec(isc_pkg::VEC_PORT_B);
    nv = n_vec;
    port_b_irq_in <= 1'b0;
    repeat (30) @(posedge clk_in);
    chk("falling_ignored", 32'(nv), 32'(n_vec));
    sleep(2'h1);
    chk("wait_halt", 32'h1, {31'h0, cpu_halt_out});
    chk("wait_osc", 32'h1, {31'h0, osc_enable_out});
    chk("wait_periph", 32'h1, {31'h0, periph_clk_enable_out});
    conv_done_flag_in <= 1'b1;
    wait_vec(isc_pkg::VEC_CONV);
    watchdog_active_in <= 1'b1;
    sleep(2'h2);
    chk("wd_osc", 32'h1, {31'h0, osc_enable_out});
    chk("wd_halt", 32'h1, {31'h0, cpu_halt_out});
    timer_zero_flag_in <= 1'b1;
    wait_vec(isc_pkg::VEC_TIMER);
    opt_in <= 1'b1;
    sleep(2'h2);
    chk("wd_stop_osc", 32'h0, {31'h0, osc_enable_out});
    chk("wd_freeze", 32'h1, {31'h0, watchdog_freeze_out});
    port_a_irq_in <= 1'b0;
    @(posedge clk_in);
    port_a_irq_in <= 1'b1;
    startup();
    wait_vec(isc_pkg::VEC_PORT_A);
    watchdog_active_in <= 1'b0;
    opt_in <= 1'b0;
    ahb(1'b1, 32'(isc_pkg::IOPT_OFFSET), 32'h0);
    nmi_pin_in <= 1'b0;
    wait_vec(isc_pkg::VEC_NMI);
    nmi_pin_in <= 1'b1;
    sleep(2'h1);
    nv = n_vec;
    nmi_pin_in <= 1'b0;
    repeat (30) @(posedge clk_in);
    chk("nmi_no_wake", 32'h1, {31'h0, cpu_halt_out});
    chk("nmi_no_vec", 32'(nv), 32'(n_vec));
    ahb(1'b1, 32'(isc_pkg::IOPT_OFFSET), 32'h10);
    wait_vec(isc_pkg::VEC_NMI);
    report_and_stop();
  end
endmodule : isc_top_tb
